/* verilog/pswc_pkg.sv */
/*
 * Constants shared by the power switch configuration register block:
 * register offsets, field positions, reset values and bus states.
 * Assumes it is compiled before every other file of the block.
 */
package pswc_pkg;

    // =====================================================================
    // Register offsets.
    // =====================================================================
    localparam logic [7:0] STATUS_OFS  = 8'h05;
    localparam logic [7:0] MASK_OFS    = 8'h07;
    localparam logic [7:0] LOCKOUT_OFS = 8'h08;
    localparam logic [7:0] HV_TRIP_OFS = 8'h09;
    localparam logic [7:0] FV_TRIP_OFS = 8'h0A;
    localparam logic [7:0] CONTROL_OFS = 8'h0B;

    // =====================================================================
    // Field widths, positions and reset values.
    // =====================================================================
    localparam int LOCKOUT_W = 3;
    localparam int TRIP_W    = 4;
    localparam int CONTROL_W = 4;

    localparam int HV_OC_BLOCK_BIT = 1;
    localparam int HV_OV_BLOCK_BIT = 0;
    localparam int ROLE_SWAP_BIT   = 3;
    localparam int FLAT_BATT_BIT   = 2;
    localparam int DISCHARGE_BIT   = 1;
    localparam int REG_OFF_BIT     = 0;

    localparam logic [LOCKOUT_W-1:0] LOCKOUT_RST = 3'h1;
    localparam logic [TRIP_W-1:0]    HV_TRIP_RST = 4'h6;
    localparam logic [TRIP_W-1:0]    FV_TRIP_RST = 4'h6;
    localparam logic [CONTROL_W-1:0] CONTROL_RST = 4'h0;
    localparam logic [7:0]           MASK_RST    = 8'h00;
    localparam logic [7:0]           STATUS_RST  = 8'h00;

    // =====================================================================
    // Serial bus slave states.
    // =====================================================================
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK,
        ST_RD_LOAD
    } pswc_state_t;

endpackage

/* verilog/pswc_link_if.sv */
/*
 * Internal carrier between the bus pin conditioner, the fault status
 * block and the register core.
 * Assumes all three modules share mclk and reset.
 */
interface pswc_link_if;
    logic       sclRise;      // Clock line rose.
    logic       sclFall;      // Clock line fell.
    logic       startSeen;    // Start or repeated start.
    logic       stopSeen;     // Stop condition.
    logic       sdaLevel;     // Registered data line level.
    logic [7:0] statusValue;  // Sticky fault flags.
    logic [7:0] clearBits;    // Flags just read, to be cleared.
    logic [7:0] blockMask;    // Interrupt block bits.

    modport pins (output sclRise, sclFall, startSeen, stopSeen, sdaLevel);
    modport stat (input clearBits, blockMask, output statusValue);
    modport core (input sclRise, sclFall, startSeen, stopSeen, sdaLevel,
                  input statusValue, output clearBits, blockMask);
endinterface

/* verilog/pswc_bus_pins.sv */
/*
 * Samples the serial clock and data pins and flags edges, start and
 * stop conditions.
 * Assumes the pins are already synchronous to mclk.
 */
module pswc_bus_pins
    import pswc_pkg::*;
(
    input  wire logic  mclk,     // System clock.
    input  wire logic  reset,    // Asynchronous reset, high.
    input  wire logic  sclPin,   // Serial clock pin level.
    input  wire logic  sdaPin,   // Serial data pin level.
    pswc_link_if.pins  link      // Conditioned events.
);

    typedef struct packed {
        logic sclNow;
        logic sclOld;
        logic sdaNow;
        logic sdaOld;
    } pswc_pins_t;

    pswc_pins_t r;
    pswc_pins_t n;

    // =====================================================================
    // State.
    // =====================================================================
    always_comb
    begin
        n        = r;
        n.sclNow = sclPin;
        n.sclOld = r.sclNow;
        n.sdaNow = sdaPin;
        n.sdaOld = r.sdaNow;
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            r <= '{sclNow: 1'b1, sclOld: 1'b1, sdaNow: 1'b1, sdaOld: 1'b1};
        end
        else
        begin
            r <= n;
        end
    end

    // =====================================================================
    // Events.
    // =====================================================================
    // A data edge while the clock stays high frames a transfer.
    assign link.sclRise   = r.sclNow & ~r.sclOld;
    assign link.sclFall   = ~r.sclNow & r.sclOld;
    assign link.startSeen = r.sclNow & r.sclOld & r.sdaOld & ~r.sdaNow;
    assign link.stopSeen  = r.sclNow & r.sclOld & ~r.sdaOld & r.sdaNow;
    assign link.sdaLevel  = r.sdaNow;

endmodule // pswc_bus_pins

/* verilog/pswc_fault_status.sv */
/*
 * Sticky fault flags, cleared by reading, and the masked interrupt pin.
 * Assumes fault events are one-cycle pulses synchronous to mclk.
 */
module pswc_fault_status
    import pswc_pkg::*;
(
    input  wire logic       mclk,        // System clock.
    input  wire logic       reset,       // Asynchronous reset, high.
    input  wire logic [7:0] faultEvent,  // Fault event pulses.
    output      logic       irqPin_n,    // Interrupt, low active.
    pswc_link_if.stat       link         // Flags and mask.
);

    typedef struct packed {
        logic [7:0] status;
        logic       irqN;
    } pswc_stat_t;

    pswc_stat_t r;
    pswc_stat_t n;

    // =====================================================================
    // Flags and interrupt.
    // =====================================================================
    always_comb
    begin
        n = r;
        // Only the bits loaded for sending by a status read are cleared, and a
        // new event in the same cycle sets its flag again.
        n.status = (r.status & ~link.clearBits) | faultEvent; // R12
        // Masked flags are still recorded but do not reach the pin.
        n.irqN = ~(|(n.status & ~link.blockMask)); // R13 R14
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            r <= '{status: STATUS_RST, irqN: 1'b1};
        end
        else
        begin
            r <= n;
        end
    end

    assign link.statusValue = r.status;
    assign irqPin_n         = r.irqN;

endmodule // pswc_fault_status

/* verilog/pswc_config_top.sv */
/*
 * Configuration register bank of a power switch, reached through a
 * serial two-wire bus slave: fault flags and mask, lockout level,
 * source trip levels and device control.
 * Assumes bus pins and fault events are synchronous to mclk and that
 * mclk is fast enough to see every bus edge.
 */
// Behaviour
// R1: Mask bit 1 blocks high-voltage source overcurrent interrupt; resets zero.
// R2: Mask bit 0 blocks high-voltage source overvoltage interrupt; resets zero.
// R3: Offset 08h holds lockout level select, reset code 01h, upper bits zero.
// R4: Offset 09h bits 3:0 hold high-voltage trip level, reset 06h.
// R5: Offset 0Ah bits 3:0 hold five-volt trip level, reset 06h.
// R6: Control bit 3 arms fast role swap.
// R7: Control bit 2 makes the device leave flat battery mode.
// R8: Control bit 1 turns on bus discharge.
// R9: Control bit 0 shuts the internal regulator down.
// R10: All control fields read zero after reset; bits 7:4 reserved.
// R11: Host reads and writes all registers through the serial bus slave; the flag register at 05h takes writes without effect.
// R12: Overcurrent flag status bit 1 sets on trip, clears on read.
// R13: Mask bits gate interrupt only; flags are still recorded.
// R14: Interrupt asserted while any unmasked flag is set.
// R15: Reserved bits ignore writes and read zero.
module pswc_config_top
    import pswc_pkg::*;
#(
    parameter logic [6:0] SLAVE_BASE = 7'h40  // Upper address bits.
)
(
    input  wire logic                 mclk,               // 100 MHz clock.
    input  wire logic                 reset,              // Async, high.
    input  wire logic                 scl,                // Bus clock in.
    input  wire logic                 sdaIn,              // Bus data in.
    output      logic                 sdaOut,             // Bus data out.
    output      logic                 sdaOe,              // Drives data low.
    input  wire logic [1:0]           addrSelect,         // Address strap.
    input  wire logic [7:0]           faultEvent,         // Fault pulses.
    output      logic                 irqPin_n,           // Interrupt, low.
    output      logic [LOCKOUT_W-1:0] lockoutLevelSelect, // Lockout level.
    output      logic [TRIP_W-1:0]    highSideTripLevel,  // HV trip level.
    output      logic [TRIP_W-1:0]    fiveVoltTripLevel,  // 5V trip level.
    output      logic                 roleSwapArm,        // Role swap armed.
    output      logic                 flatBatteryLeave,   // Leave flat batt.
    output      logic                 busDischargeOn,     // Discharge on.
    output      logic                 regulatorOff        // Regulator off.
);

    // =====================================================================
    // State record.
    // =====================================================================
    typedef struct packed {
        pswc_state_t          state;
        logic [2:0]           bitCnt;
        logic [7:0]           shift;
        logic [7:0]           pointer;
        logic                 gotPointer;
        logic                 readDir;
        logic                 sdaDrive;
        logic [7:0]           clearBits;
        logic [LOCKOUT_W-1:0] lockout;
        logic [TRIP_W-1:0]    hvTrip;
        logic [TRIP_W-1:0]    fvTrip;
        logic [CONTROL_W-1:0] control;
        logic [7:0]           mask;
    } pswc_core_t;

    localparam pswc_core_t CORE_RST = '{
        state:      ST_IDLE,
        bitCnt:     3'h0,
        shift:      8'h00,
        pointer:    8'h00,
        gotPointer: 1'b0,
        readDir:    1'b0,
        sdaDrive:   1'b0,
        clearBits:  8'h00,
        lockout:    LOCKOUT_RST,
        hvTrip:     HV_TRIP_RST,
        fvTrip:     FV_TRIP_RST,
        control:    CONTROL_RST,
        mask:       MASK_RST
    };

    pswc_core_t r;
    pswc_core_t n;
    logic [7:0] rxByte;

    pswc_link_if link ();

    // =====================================================================
    // Sub-blocks.
    // =====================================================================
    pswc_bus_pins u_pins (
        .mclk   (mclk),
        .reset  (reset),
        .sclPin (scl),
        .sdaPin (sdaIn),
        .link   (link)
    );

    pswc_fault_status u_status (
        .mclk       (mclk),
        .reset      (reset),
        .faultEvent (faultEvent),
        .irqPin_n   (irqPin_n),
        .link       (link)
    );

    // =====================================================================
    // Register access helpers.
    // =====================================================================
    // Unmapped offsets and reserved bits read as zero.
    function automatic logic [7:0] regRead(
        input logic [7:0] ofs,
        input pswc_core_t s,
        input logic [7:0] stat
    );
        case (ofs)
            STATUS_OFS:  regRead = stat;
            MASK_OFS:    regRead = s.mask;
            LOCKOUT_OFS: regRead = 8'(s.lockout); // R3 R15
            HV_TRIP_OFS: regRead = 8'(s.hvTrip); // R4 R15
            FV_TRIP_OFS: regRead = 8'(s.fvTrip); // R5 R15
            CONTROL_OFS: regRead = 8'(s.control); // R10 R15
            default:     regRead = 8'h00;
        endcase
    endfunction

    // Loads the byte at the pointer for sending and advances the pointer.
    // Reading the status offset hands the read value back for clearing.
    function automatic pswc_core_t loadRead(
        input pswc_core_t s,
        input logic [7:0] stat
    );
        pswc_core_t t;
        t          = s;
        t.shift    = regRead(s.pointer, s, stat); // R11
        t.sdaDrive = ~t.shift[7];
        t.bitCnt   = 3'h0;
        t.pointer  = s.pointer + 8'h01;
        t.state    = ST_RD_BYTE;
        if (s.pointer == STATUS_OFS)
        begin
            t.clearBits = stat; // R12
        end
        return t;
    endfunction

    // Stores a data byte at the pointer; the flag register and unmapped
    // offsets take writes without effect.
    function automatic pswc_core_t storeWrite(
        input pswc_core_t s,
        input logic [7:0] d
    );
        pswc_core_t t;
        t = s;
        case (s.pointer)
            MASK_OFS:    t.mask    = d; // R1 R2
            LOCKOUT_OFS: t.lockout = d[LOCKOUT_W-1:0]; // R3 R15
            HV_TRIP_OFS: t.hvTrip  = d[TRIP_W-1:0]; // R4 R15
            FV_TRIP_OFS: t.fvTrip  = d[TRIP_W-1:0]; // R5 R15
            CONTROL_OFS: t.control = d[CONTROL_W-1:0]; // R6 R7 R8 R9 R15
            default:     t.mask    = s.mask;
        endcase
        t.pointer = s.pointer + 8'h01;
        return t;
    endfunction

    // =====================================================================
    // Bus slave sequencing.
    // =====================================================================
    // Data is taken on the rising bus clock and changed only after the
    // falling edge, so the slave never moves the line while clock is high.
    always_comb
    begin
        n           = r;
        n.clearBits = 8'h00;
        rxByte      = {r.shift[6:0], link.sdaLevel};
        if (link.startSeen)
        begin
            n.state      = ST_ADDR;
            n.bitCnt     = 3'h0;
            n.gotPointer = 1'b0;
            n.sdaDrive   = 1'b0;
        end
        else if (link.stopSeen)
        begin
            n.state    = ST_IDLE;
            n.sdaDrive = 1'b0;
        end
        else
        begin
            case (r.state)
                ST_IDLE:
                begin
                    n.sdaDrive = 1'b0;
                end
                ST_ADDR:
                begin
                    if (link.sclRise)
                    begin
                        n.shift  = rxByte;
                        n.bitCnt = r.bitCnt + 3'h1;
                        if (r.bitCnt == 3'h7)
                        begin
                            n.readDir = rxByte[0];
                            if (rxByte[7:1] == {SLAVE_BASE[6:2], addrSelect})
                            begin
                                n.state = ST_ADDR_ACK; // R11
                            end
                            else
                            begin
                                n.state = ST_IDLE;
                            end
                        end
                    end
                end
                ST_ADDR_ACK:
                begin
                    if (link.sclFall && !r.sdaDrive)
                    begin
                        n.sdaDrive = 1'b1;
                    end
                    else if (link.sclFall && r.readDir)
                    begin
                        n = loadRead(r, link.statusValue);
                    end
                    else if (link.sclFall)
                    begin
                        n.sdaDrive = 1'b0;
                        n.bitCnt   = 3'h0;
                        n.state    = ST_WR_BYTE;
                    end
                end
                ST_WR_BYTE:
                begin
                    if (link.sclRise)
                    begin
                        n.shift  = rxByte;
                        n.bitCnt = r.bitCnt + 3'h1;
                        if (r.bitCnt == 3'h7)
                        begin
                            n.state = ST_WR_ACK;
                            if (!r.gotPointer)
                            begin
                                n.pointer    = rxByte;
                                n.gotPointer = 1'b1;
                            end
                            else
                            begin
                                n = storeWrite(n, rxByte); // R11
                            end
                        end
                    end
                end
                ST_WR_ACK:
                begin
                    if (link.sclFall && !r.sdaDrive)
                    begin
                        n.sdaDrive = 1'b1;
                    end
                    else if (link.sclFall)
                    begin
                        n.sdaDrive = 1'b0;
                        n.bitCnt   = 3'h0;
                        n.state    = ST_WR_BYTE;
                    end
                end
                ST_RD_BYTE:
                begin
                    if (link.sclFall && r.bitCnt == 3'h7)
                    begin
                        n.sdaDrive = 1'b0;
                        n.state    = ST_RD_ACK;
                    end
                    else if (link.sclFall)
                    begin
                        n.bitCnt   = r.bitCnt + 3'h1;
                        n.shift    = {r.shift[6:0], 1'b0};
                        n.sdaDrive = ~r.shift[6];
                    end
                end
                ST_RD_ACK:
                begin
                    // A refusal from the host ends the read; the slave
                    // then waits quietly for stop or a new start.
                    if (link.sclRise)
                    begin
                        n.state = link.sdaLevel ? ST_IDLE : ST_RD_LOAD;
                    end
                end
                ST_RD_LOAD:
                begin
                    if (link.sclFall)
                    begin
                        n = loadRead(r, link.statusValue);
                    end
                end
                default:
                begin
                    n.state    = ST_IDLE;
                    n.sdaDrive = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            r <= CORE_RST; // R10
        end
        else
        begin
            r <= n;
        end
    end

    // =====================================================================
    // Outputs.
    // =====================================================================
    assign link.clearBits = r.clearBits;
    assign link.blockMask = r.mask; // R1 R2 R13
    assign sdaOut         = 1'b0;
    assign sdaOe          = r.sdaDrive;

    assign lockoutLevelSelect = r.lockout;
    assign highSideTripLevel  = r.hvTrip;
    assign fiveVoltTripLevel  = r.fvTrip;
    assign roleSwapArm        = r.control[ROLE_SWAP_BIT]; // R6
    assign flatBatteryLeave   = r.control[FLAT_BATT_BIT]; // R7
    assign busDischargeOn     = r.control[DISCHARGE_BIT]; // R8
    assign regulatorOff       = r.control[REG_OFF_BIT]; // R9

endmodule // pswc_config_top

/* bench/pswc_config_top_chk.sv */
/*
 * Port checks of the power switch configuration block.
 * Assumes one clock, mclk, and the asynchronous high reset.
 */
module pswc_config_top_chk
    import pswc_pkg::*;
(
    input logic                 mclk,               // Clock.
    input logic                 reset,              // Reset.
    input logic                 scl,                // Bus clock.
    input logic                 sdaOe,              // Data pull.
    input logic [7:0]           faultEvent,         // Faults.
    input logic                 irqPin_n,           // Interrupt.
    input logic [LOCKOUT_W-1:0] lockoutLevelSelect, // Lockout.
    input logic [TRIP_W-1:0]    highSideTripLevel,  // HV trip.
    input logic [TRIP_W-1:0]    fiveVoltTripLevel,  // 5V trip.
    input logic                 roleSwapArm,        // Swap arm.
    input logic                 flatBatteryLeave,   // Leave.
    input logic                 busDischargeOn,     // Discharge.
    input logic                 regulatorOff        // Reg off.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    a_reset_levels: assert property (
        $fell(reset) |-> lockoutLevelSelect == LOCKOUT_RST
            && highSideTripLevel == HV_TRIP_RST
            && fiveVoltTripLevel == FV_TRIP_RST)
        else $error("Levels wrong after reset.");
    a_reset_control: assert property (
        $fell(reset) |-> {roleSwapArm, flatBatteryLeave, busDischargeOn,
            regulatorOff} == CONTROL_RST)
        else $error("Controls wrong after reset.");
    a_reset_pins: assert property (
        $fell(reset) |-> irqPin_n && !sdaOe)
        else $error("Pins active after reset.");
    a_levels_write: assert property (
        !$stable({lockoutLevelSelect, highSideTripLevel,
            fiveVoltTripLevel}) |-> scl && $past(scl))
        else $error("Level changed off a write.");
    a_control_write: assert property (
        !$stable({roleSwapArm, flatBatteryLeave, busDischargeOn,
            regulatorOff}) |-> scl && $past(scl))
        else $error("Control changed off a write.");
    a_ack_scl_low: assert property (
        $changed(sdaOe) |-> !scl)
        else $error("Data pull moved with clock high.");
    a_oe_holds: assert property (
        $rose(sdaOe) |=> sdaOe [*4])
        else $error("Data pull released too early.");
    a_irq_cause: assert property (
        $fell(irqPin_n) |-> $past(faultEvent) != 8'h00 || scl)
        else $error("Interrupt fell without a cause.");
endmodule // pswc_config_top_chk

bind pswc_config_top pswc_config_top_chk u_chk (
    .mclk(mclk), .reset(reset), .scl(scl), .sdaOe(sdaOe),
    .faultEvent(faultEvent), .irqPin_n(irqPin_n),
    .lockoutLevelSelect(lockoutLevelSelect),
    .highSideTripLevel(highSideTripLevel),
    .fiveVoltTripLevel(fiveVoltTripLevel), .roleSwapArm(roleSwapArm),
    .flatBatteryLeave(flatBatteryLeave),
    .busDischargeOn(busDischargeOn), .regulatorOff(regulatorOff));

/* bench/pswc_i2c_host.sv */
/*
 * Two-wire bus host model with register write and read tasks.
 * Assumes a pull-up on the data wire; all moves follow mclk edges.
 */
module pswc_i2c_host (
    input  logic mclk,    // System clock.
    output logic scl,     // Bus clock.
    output logic sdaDrv,  // Data, low pulls.
    input  logic sdaWire  // Resolved data.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] addr7 = 7'h41;
    int         nacks = 0;
    initial {scl, sdaDrv} = 2'b11;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Data moves only while the clock is low; each phase is 4 cycles.
    task automatic put(input logic b, output logic s);
        sdaDrv <= b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        s = sdaWire;
        scl <= 1'b0;
        tick(2);
    endtask
    // High opens a transfer, low closes it and leaves the bus idle.
    task automatic frame(input logic b);
        sdaDrv <= b;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sdaDrv <= ~b;
        tick(4);
        if (b)
        begin
            scl <= 1'b0;
            tick(2);
        end
    endtask
    // Ninth bit released; a read ends with a host NACK.
    task automatic xfer(input logic [7:0] d, input logic rd,
                        output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--)
            put(d[i], q[i]);
        put(1'b1, a);
        if (!rd && a)
            nacks++;
    endtask
    task automatic wr_reg(input logic [7:0] ofs, input logic [7:0] d);
        logic [7:0] q;
        frame(1'b1);
        xfer({addr7, 1'b0}, 1'b0, q);
        xfer(ofs, 1'b0, q);
        xfer(d, 1'b0, q);
        frame(1'b0);
    endtask
    task automatic rd_reg(input logic [7:0] ofs, output logic [7:0] q);
        frame(1'b1);
        xfer({addr7, 1'b0}, 1'b0, q);
        xfer(ofs, 1'b0, q);
        frame(1'b1);
        xfer({addr7, 1'b1}, 1'b0, q);
        xfer(8'hFF, 1'b1, q);
        frame(1'b0);
    endtask
endmodule // pswc_i2c_host

/* bench/pswc_config_top_tb.sv */
/*
 * Self-checking bench of the power switch configuration registers.
 * Assumes the host model drives the bus and the bench the faults.
 */
module pswc_config_top_tb
    import pswc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic                 mclk, reset, scl, sdaDrv, sdaOe, sdaOut, irqPin_n;
    logic [7:0]           faultEvent;
    logic [LOCKOUT_W-1:0] lock;
    logic [TRIP_W-1:0]    hv, fv;
    logic [3:0]           ctl;
    int                   errTotal = 0;
    int                   comparisons = 0;
    wire logic            sdaWire = sdaDrv & (~sdaOe | sdaOut);

    pswc_i2c_host host (.mclk(mclk), .scl(scl), .sdaDrv(sdaDrv),
                        .sdaWire(sdaWire));
    pswc_config_top dut (
        .mclk(mclk), .reset(reset), .scl(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelect(2'b01),
        .faultEvent(faultEvent), .irqPin_n(irqPin_n),
        .lockoutLevelSelect(lock), .highSideTripLevel(hv),
        .fiveVoltTripLevel(fv), .roleSwapArm(ctl[3]),
        .flatBatteryLeave(ctl[2]), .busDischargeOn(ctl[1]),
        .regulatorOff(ctl[0]));

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic giveVerdict();
        $display("errors %0d comparisons %0d", errTotal, comparisons);
        if (errTotal == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] ofs,
                          input logic [7:0] exp);
        logic [7:0] v;
        host.rd_reg(ofs, v);
        check(nm, v, exp);
    endtask
    task automatic pulse(input logic [7:0] ev);
        faultEvent <= ev;
        @(posedge mclk);
        faultEvent <= 8'h00;
        @(posedge mclk);
    endtask

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        errTotal++;
        giveVerdict();
    end
    initial
    begin
        reset = 1'b1;
        faultEvent = 8'h00;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        check("lock", 8'(lock), 8'h01);
        check("hv", 8'(hv), 8'h06);
        check("fv", 8'(fv), 8'h06);
        check("ctl", 8'(ctl), 8'h00);
        check("irq", 8'(irqPin_n), 8'h01);
        rd_chk("rdLock", LOCKOUT_OFS, 8'h01);
        rd_chk("rdHv", HV_TRIP_OFS, 8'h06);
        rd_chk("rdFv", FV_TRIP_OFS, 8'h06);
        rd_chk("rdCtl", CONTROL_OFS, 8'h00);
        rd_chk("rdMask", MASK_OFS, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            host.wr_reg(CONTROL_OFS, 8'h01 << i);
            check("ctlBit", 8'(ctl), 8'h01 << i);
        end
        host.wr_reg(CONTROL_OFS, 8'hFF);
        check("ctlAll", 8'(ctl), 8'h0F);
        rd_chk("rdCtl", CONTROL_OFS, 8'h0F);
        host.wr_reg(LOCKOUT_OFS, 8'hFE);
        check("lock", 8'(lock), 8'h06);
        rd_chk("rdLock", LOCKOUT_OFS, 8'h06);
        host.wr_reg(HV_TRIP_OFS, 8'hA5);
        host.wr_reg(FV_TRIP_OFS, 8'h3C);
        check("hv", 8'(hv), 8'h05);
        check("fv", 8'(fv), 8'h0C);
        rd_chk("rdHv", HV_TRIP_OFS, 8'h05);
        rd_chk("rdFv", FV_TRIP_OFS, 8'h0C);
        rd_chk("rdNone", 8'h20, 8'h00);
        check("nacks", 8'(host.nacks), 8'h00);
        // A foreign slave address must leave the control register alone.
        host.addr7 = 7'h42;
        host.wr_reg(CONTROL_OFS, 8'h00);
        host.addr7 = 7'h41;
        check("nacks", 8'(host.nacks), 8'h03);
        check("ctlKept", 8'(ctl), 8'h0F);
        pulse(8'h02);
        check("irqOc", 8'(irqPin_n), 8'h00);
        rd_chk("stat", STATUS_OFS, 8'h02);
        check("irqClr", 8'(irqPin_n), 8'h01);
        rd_chk("statClr", STATUS_OFS, 8'h00);
        host.wr_reg(MASK_OFS, 8'h03);
        rd_chk("rdMask", MASK_OFS, 8'h03);
        pulse(8'h03);
        check("irqMasked", 8'(irqPin_n), 8'h01);
        rd_chk("statMasked", STATUS_OFS, 8'h03);
        host.wr_reg(MASK_OFS, 8'h02);
        pulse(8'h01);
        check("irqOv", 8'(irqPin_n), 8'h00);
        rd_chk("statOv", STATUS_OFS, 8'h01);
        host.wr_reg(MASK_OFS, 8'h01);
        pulse(8'h02);
        check("irqOc", 8'(irqPin_n), 8'h00);
        rd_chk("statOc", STATUS_OFS, 8'h02);
        check("irqEnd", 8'(irqPin_n), 8'h01);
        giveVerdict();
    end
endmodule // pswc_config_top_tb
